// File: hdl/vsrmc_pkg.sv
// Package: register offsets, field positions, reset values and carriers of the voice block
package vsrmc_pkg;

    // Byte register offsets on the register port
    localparam logic [4:0] OFS_V1_FREQ_LO = 5'h00;
    localparam logic [4:0] OFS_V1_FREQ_HI = 5'h01;
    localparam logic [4:0] OFS_V1_WAVE    = 5'h04;
    localparam logic [4:0] OFS_V1_ATK_DEC = 5'h05;
    localparam logic [4:0] OFS_V3_FREQ_LO = 5'h0E;
    localparam logic [4:0] OFS_V3_FREQ_HI = 5'h0F;
    localparam logic [4:0] OFS_V3_WAVE    = 5'h12;
    localparam logic [4:0] OFS_CUT_LO     = 5'h15;
    localparam logic [4:0] OFS_CUT_HI     = 5'h16;
    localparam logic [4:0] OFS_FLT_ROUTE  = 5'h17;
    localparam logic [4:0] OFS_MODE_VOL   = 5'h18;
    localparam logic [4:0] OFS_OSC3_OUT   = 5'h1B;

    // Voice waveform control fields
    localparam int BIT_GATE      = 0;
    localparam int BIT_SYNC      = 1;
    localparam int BIT_RING      = 3;
    localparam int BIT_TRIANGLE  = 4;
    localparam int BIT_SAWTOOTH  = 5;
    localparam int BIT_PULSE     = 6;
    localparam int BIT_NOISE     = 7;

    // Master control and routing fields
    localparam int BIT_LOWPASS   = 4;
    localparam int BIT_BANDPASS  = 5;
    localparam int BIT_HIGHPASS  = 6;
    localparam int BIT_V3_MUTE   = 7;
    localparam int BIT_ROUTE_V1  = 0;

    // Reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [22:0] RST_NOISE = 23'h7FFFF8;

    // Filter control carried to the analogue side
    typedef struct packed {
        logic [10:0] cutoff;
        logic        routeV1;
        logic        highPass;
        logic        bandPass;
        logic        lowPass;
        logic [3:0]  volume;
        logic        voice3Mute;
    } vsrmc_filter_t;

endpackage : vsrmc_pkg

// File: hdl/vsrmc_voice_ctrl.sv
// Voice 1 control with sync and ring coupling to oscillator 3, filter and volume registers
//
// Operation
// - With sync on, voice 1 output is zero whenever either coupled waveform is zero.
// - Waveform control bit 1 enables syncing voice 1 to voice 3.
// - Waveform control bit 0 gates voice 1; bit 4 selects triangle.
// - Bit 3 replaces oscillator 1 triangle with ring mix of oscillators 1 and 3.
// - Master control holds volume, 15 full and 0 silent, plus high-pass select.
// - Writing 1 to the routing register sends voice 1 through the filter.
// - A dedicated register holds cutoff high byte; a write updates the cutoff.
// - Voice 3 frequency high byte sets the modulating oscillator rate.
// - Attack and decay share one register, applied when the voice is gated.
// - Master control bit 6 high-pass, bit 5 band-pass, bit 4 low-pass.
// - Master control bit 7 mutes voice 3 audio, oscillator keeps running.
module vsrmc_voice_ctrl #(
    parameter int          PHASE_W      = 24,
    parameter logic [11:0] ENV_STEP_CYC = 12'h010
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    // Register port
    input  wire logic [4:0]             regAddr,
    input  wire logic [7:0]             regWrData,
    input  wire logic                   regWrEn,
    input  wire logic                   regRdEn,
    output logic      [7:0]             regRdData,
    // Audio and filter control
    output logic      [7:0]             voice1Sample,
    output logic      [7:0]             voice3Sample,
    output logic      [8:0]             dryMix,
    output logic      [8:0]             filterFeed,
    output vsrmc_pkg::vsrmc_filter_t    filterCtrl
);

    typedef enum {ENV_IDLE, ENV_ATTACK, ENV_DECAY, ENV_RELEASE} vsrmc_env_t;

    logic [7:0]         v1FreqLo_r, v1FreqHi_r, v1Wave_r, v1AtkDec_r;
    logic [7:0]         v3FreqLo_r, v3FreqHi_r, v3Wave_r;
    logic [2:0]         cutLo_r;
    logic [7:0]         cutHi_r, route_r, modeVol_r;
    logic [PHASE_W-1:0] phase1_r, phase3_r;
    logic               msb3Prev_r, noiseClkPrev_r, gatePrev_r;
    logic [22:0]        noise_r;
    logic [7:0]         atkDecAct_r, env_r;
    logic [15:0]        envCnt_r;
    vsrmc_env_t         envState_r;
    logic [7:0]         osc3Out_r;

    logic [7:0]         triWave1, wave1, wave3;
    logic               msb1Eff, syncReset;
    logic [15:0]        envPeriod, prod1;
    logic [8:0]         drySum;
    logic [12:0]        dryScaled, feedScaled;

    // Register writes; every stored byte updates on the cycle of its strobe
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            v1FreqLo_r <= vsrmc_pkg::RST_BYTE;
            v1FreqHi_r <= vsrmc_pkg::RST_BYTE;
            v1Wave_r   <= vsrmc_pkg::RST_BYTE;
            v1AtkDec_r <= vsrmc_pkg::RST_BYTE;
            v3FreqLo_r <= vsrmc_pkg::RST_BYTE;
            v3FreqHi_r <= vsrmc_pkg::RST_BYTE;
            v3Wave_r   <= vsrmc_pkg::RST_BYTE;
            cutLo_r    <= 3'h0;
            cutHi_r    <= vsrmc_pkg::RST_BYTE;
            route_r    <= vsrmc_pkg::RST_BYTE;
            modeVol_r  <= vsrmc_pkg::RST_BYTE;
        end else if (regWrEn) begin
            if (regAddr == vsrmc_pkg::OFS_V1_FREQ_LO) begin
                v1FreqLo_r <= regWrData;
            end else if (regAddr == vsrmc_pkg::OFS_V1_FREQ_HI) begin
                v1FreqHi_r <= regWrData;
            end else if (regAddr == vsrmc_pkg::OFS_V1_WAVE) begin
                v1Wave_r <= regWrData;
            end else if (regAddr == vsrmc_pkg::OFS_V1_ATK_DEC) begin
                v1AtkDec_r <= regWrData;
            end else if (regAddr == vsrmc_pkg::OFS_V3_FREQ_LO) begin
                v3FreqLo_r <= regWrData;
            end else if (regAddr == vsrmc_pkg::OFS_V3_FREQ_HI) begin
                v3FreqHi_r <= regWrData;
            end else if (regAddr == vsrmc_pkg::OFS_V3_WAVE) begin
                v3Wave_r <= regWrData;
            end else if (regAddr == vsrmc_pkg::OFS_CUT_LO) begin
                cutLo_r <= regWrData[2:0];
            end else if (regAddr == vsrmc_pkg::OFS_CUT_HI) begin
                cutHi_r <= regWrData;
            end else if (regAddr == vsrmc_pkg::OFS_FLT_ROUTE) begin
                route_r <= regWrData;
            end else if (regAddr == vsrmc_pkg::OFS_MODE_VOL) begin
                modeVol_r <= regWrData;
            end
        end
    end

    // Register reads; unmapped offsets answer zero
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            regRdData <= vsrmc_pkg::RST_BYTE;
        end else if (regRdEn) begin
            if (regAddr == vsrmc_pkg::OFS_V1_FREQ_LO) begin
                regRdData <= v1FreqLo_r;
            end else if (regAddr == vsrmc_pkg::OFS_V1_FREQ_HI) begin
                regRdData <= v1FreqHi_r;
            end else if (regAddr == vsrmc_pkg::OFS_V1_WAVE) begin
                regRdData <= v1Wave_r;
            end else if (regAddr == vsrmc_pkg::OFS_V1_ATK_DEC) begin
                regRdData <= v1AtkDec_r;
            end else if (regAddr == vsrmc_pkg::OFS_V3_FREQ_LO) begin
                regRdData <= v3FreqLo_r;
            end else if (regAddr == vsrmc_pkg::OFS_V3_FREQ_HI) begin
                regRdData <= v3FreqHi_r;
            end else if (regAddr == vsrmc_pkg::OFS_V3_WAVE) begin
                regRdData <= v3Wave_r;
            end else if (regAddr == vsrmc_pkg::OFS_CUT_LO) begin
                regRdData <= {5'h00, cutLo_r};
            end else if (regAddr == vsrmc_pkg::OFS_CUT_HI) begin
                regRdData <= cutHi_r;
            end else if (regAddr == vsrmc_pkg::OFS_FLT_ROUTE) begin
                regRdData <= route_r;
            end else if (regAddr == vsrmc_pkg::OFS_MODE_VOL) begin
                regRdData <= modeVol_r;
            end else if (regAddr == vsrmc_pkg::OFS_OSC3_OUT) begin
                regRdData <= osc3Out_r; // Live oscillator 3 output, envelope does not touch it
            end else begin
                regRdData <= vsrmc_pkg::RST_BYTE;
            end
        end
    end

    // Sync restarts oscillator 1 on the edge after the oscillator 3 phase MSB rises
    assign syncReset = v1Wave_r[vsrmc_pkg::BIT_SYNC] && !msb3Prev_r
                       && phase3_r[PHASE_W-1];

    // Phase accumulators step every cycle; oscillator 3 runs even when muted
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            phase1_r   <= '0;
            phase3_r   <= '0;
            msb3Prev_r <= 1'b0;
        end else begin
            phase3_r   <= phase3_r + PHASE_W'({v3FreqHi_r, v3FreqLo_r});
            msb3Prev_r <= phase3_r[PHASE_W-1];
            if (syncReset) begin
                phase1_r <= '0;
            end else begin
                phase1_r <= phase1_r + PHASE_W'({v1FreqHi_r, v1FreqLo_r});
            end
        end
    end

    // Noise source shifts on each rise of phase bit PHASE_W-5 of oscillator 3
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            noise_r        <= vsrmc_pkg::RST_NOISE;
            noiseClkPrev_r <= 1'b0;
        end else begin
            noiseClkPrev_r <= phase3_r[PHASE_W-5];
            if (phase3_r[PHASE_W-5] && !noiseClkPrev_r) begin
                noise_r <= {noise_r[21:0], noise_r[22] ^ noise_r[17]};
            end
        end
    end

    // Oscillator 3 waveform; several selected waves are ANDed together
    always_comb begin
        wave3 = 8'hFF;
        if (v3Wave_r[vsrmc_pkg::BIT_TRIANGLE]) begin
            wave3 = wave3 & (phase3_r[PHASE_W-1] ? ~phase3_r[PHASE_W-2 -: 8]
                                                 : phase3_r[PHASE_W-2 -: 8]);
        end
        if (v3Wave_r[vsrmc_pkg::BIT_SAWTOOTH]) begin
            wave3 = wave3 & phase3_r[PHASE_W-1 -: 8];
        end
        if (v3Wave_r[vsrmc_pkg::BIT_PULSE]) begin
            wave3 = wave3 & {8{phase3_r[PHASE_W-1]}};
        end
        if (v3Wave_r[vsrmc_pkg::BIT_NOISE]) begin
            wave3 = wave3 & noise_r[22:15];
        end
        if (v3Wave_r[7:4] == 4'h0) begin
            wave3 = 8'h00; // No wave selected means a silent oscillator
        end
    end

    // Voice 1 triangle, ring folding and sync gating
    always_comb begin
        msb1Eff = phase1_r[PHASE_W-1];
        if (v1Wave_r[vsrmc_pkg::BIT_RING]) begin
            msb1Eff = phase1_r[PHASE_W-1] ^ phase3_r[PHASE_W-1];
        end
        triWave1 = msb1Eff ? ~phase1_r[PHASE_W-2 -: 8] : phase1_r[PHASE_W-2 -: 8];
        wave1    = v1Wave_r[vsrmc_pkg::BIT_TRIANGLE] ? triWave1 : 8'h00;
        if (v1Wave_r[vsrmc_pkg::BIT_SYNC] && (wave3 == 8'h00)) begin
            wave1 = 8'h00;
        end
    end

    // Envelope period; rate tables are left out, so the field scales a base step
    assign envPeriod = 16'(ENV_STEP_CYC) * 16'({12'h000,
                       (envState_r == ENV_ATTACK) ? atkDecAct_r[7:4] : atkDecAct_r[3:0]} + 16'h0001);

    // Envelope: gate rise latches attack and decay, gate fall releases
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            envState_r  <= ENV_IDLE;
            env_r       <= 8'h00;
            envCnt_r    <= 16'h0000;
            atkDecAct_r <= 8'h00;
            gatePrev_r  <= 1'b0;
        end else begin
            gatePrev_r <= v1Wave_r[vsrmc_pkg::BIT_GATE];
            if (v1Wave_r[vsrmc_pkg::BIT_GATE] && !gatePrev_r) begin
                atkDecAct_r <= v1AtkDec_r;
                envState_r  <= ENV_ATTACK;
                envCnt_r    <= 16'h0000;
            end else if (!v1Wave_r[vsrmc_pkg::BIT_GATE] && gatePrev_r) begin
                envState_r <= ENV_RELEASE;
                envCnt_r   <= 16'h0000;
            end else if (envCnt_r + 16'h0001 >= envPeriod) begin
                envCnt_r <= 16'h0000;
                case (envState_r)
                    ENV_ATTACK: begin
                        if (env_r == 8'hFF) begin
                            envState_r <= ENV_DECAY;
                        end else begin
                            env_r <= env_r + 8'h01;
                        end
                    end
                    ENV_DECAY, ENV_RELEASE: begin
                        if (env_r == 8'h00) begin
                            envState_r <= ENV_IDLE;
                        end else begin
                            env_r <= env_r - 8'h01;
                        end
                    end
                    default: begin
                        env_r <= 8'h00;
                    end
                endcase
            end else begin
                envCnt_r <= envCnt_r + 16'h0001;
            end
        end
    end

    // Amplitude and mixing; volume scales both paths so 0 gives silence
    assign prod1      = wave1 * env_r;
    assign drySum     = (route_r[vsrmc_pkg::BIT_ROUTE_V1] ? 9'h000 : {1'b0, voice1Sample})
                        + {1'b0, voice3Sample};
    assign dryScaled  = drySum * modeVol_r[3:0];
    assign feedScaled = (route_r[vsrmc_pkg::BIT_ROUTE_V1] ? {1'b0, voice1Sample} : 9'h000)
                        * modeVol_r[3:0];

    // Registered audio outputs; samples one cycle behind the oscillators, mixes two
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            voice1Sample <= 8'h00;
            voice3Sample <= 8'h00;
            osc3Out_r    <= 8'h00;
            dryMix       <= 9'h000;
            filterFeed   <= 9'h000;
        end else begin
            voice1Sample <= prod1[15:8];
            osc3Out_r    <= wave3;
            voice3Sample <= modeVol_r[vsrmc_pkg::BIT_V3_MUTE] ? 8'h00 : wave3;
            dryMix       <= dryScaled[12:4];
            filterFeed   <= feedScaled[12:4];
        end
    end

    // Filter control follows its registers one cycle after a write
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            filterCtrl <= '0;
        end else begin
            filterCtrl.cutoff     <= {cutHi_r, cutLo_r};
            filterCtrl.routeV1    <= route_r[vsrmc_pkg::BIT_ROUTE_V1];
            filterCtrl.highPass   <= modeVol_r[vsrmc_pkg::BIT_HIGHPASS];
            filterCtrl.bandPass   <= modeVol_r[vsrmc_pkg::BIT_BANDPASS];
            filterCtrl.lowPass    <= modeVol_r[vsrmc_pkg::BIT_LOWPASS];
            filterCtrl.volume     <= modeVol_r[3:0];
            filterCtrl.voice3Mute <= modeVol_r[vsrmc_pkg::BIT_V3_MUTE];
        end
    end

endmodule : vsrmc_voice_ctrl

// File: tb/vsrmc_voice_ctrl_assertions.sv
// Checker: port-level properties of the voice control block
module vsrmc_voice_ctrl_assertions (
    // Clock and reset
    input wire logic                     core_clk,
    input wire logic                     resetn,
    // Register port
    input wire logic [4:0]               regAddr,
    input wire logic [7:0]               regWrData,
    input wire logic                     regWrEn,
    input wire logic                     regRdEn,
    input wire logic [7:0]               regRdData,
    // Audio and filter control
    input wire logic [7:0]               voice1Sample,
    input wire logic [7:0]               voice3Sample,
    input wire logic [8:0]               dryMix,
    input wire logic [8:0]               filterFeed,
    input wire vsrmc_pkg::vsrmc_filter_t filterCtrl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wave_r;
    logic       gated_r;
    logic       wrMode;
    logic       wrWave;
    // Write decodes seen at the port
    assign wrMode = regWrEn && regAddr == 5'h18;
    assign wrWave = regWrEn && regAddr == 5'h04;
    // Shadow of the voice 1 control byte, since the checker cannot see inside
    always_ff @(posedge core_clk) begin
        if (!resetn) wave_r <= 8'h00;
        else if (wrWave) wave_r <= regWrData;
    end
    // Remembers whether the gate was ever raised since reset
    always_ff @(posedge core_clk) begin
        if (!resetn) gated_r <= 1'b0;
        else if (wrWave && regWrData[0]) gated_r <= 1'b1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Volume and high-pass bits are compared with the byte written two edges earlier
    AST_VOLUME: assert property (wrMode |-> ##2
        {filterCtrl.highPass, filterCtrl.volume}
        == {$past(regWrData[6], 2), $past(regWrData[3:0], 2)})
        else $error("volume field wrong");
    AST_FILTER_TYPE: assert property (wrMode |-> ##2
        {filterCtrl.highPass, filterCtrl.bandPass, filterCtrl.lowPass} == $past(regWrData[6:4], 2))
        else $error("filter type wrong");
    AST_MUTE_FLAG: assert property (wrMode |-> ##2
        filterCtrl.voice3Mute == $past(regWrData[7], 2))
        else $error("voice 3 mute flag wrong");
    AST_V3_SILENT: assert property (filterCtrl.voice3Mute && $past(filterCtrl.voice3Mute)
        |-> voice3Sample == 8'h00) else $error("muted voice 3 audible");
    AST_ROUTE: assert property (regWrEn && regAddr == 5'h17 |-> ##2
        filterCtrl.routeV1 == $past(regWrData[0], 2)) else $error("routing wrong");
    AST_CUTOFF_HI: assert property (regWrEn && regAddr == 5'h16 |-> ##2
        filterCtrl.cutoff[10:3] == $past(regWrData, 2)) else $error("cutoff high wrong");
    AST_WAVE_READBACK: assert property (regRdEn && regAddr == 5'h04 |=>
        regRdData == $past(wave_r)) else $error("control readback wrong");
    AST_NO_TRI_SILENT: assert property (!wave_r[4] [*4] |-> voice1Sample == 8'h00)
        else $error("voice 1 sounds without triangle");
    AST_GATE_IDLE: assert property (!gated_r |-> voice1Sample == 8'h00)
        else $error("envelope active before gate");
    AST_SYNC_AND: assert property (wave_r[1] && $past(wave_r[1])
        && !filterCtrl.voice3Mute && !$past(filterCtrl.voice3Mute)
        && voice3Sample == 8'h00 |-> voice1Sample == 8'h00)
        else $error("sync output not zero");
    // Main scenarios reached
    COV_MODE: cover property (wrMode);
    COV_RING: cover property (wave_r[3] && voice1Sample != 8'h00);
    COV_FEED: cover property (filterFeed != 9'h000 && dryMix == 9'h000);
endmodule : vsrmc_voice_ctrl_assertions

// File: tb/vsrmc_voice_ctrl_tb.sv
// Testbench: register access, filter control and voice coupling scenarios
module vsrmc_voice_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     core_clk = 1'b0;
    logic                     resetn = 1'b0;
    logic [4:0]               regAddr = 5'h00;
    logic [7:0]               regWrData = 8'h00;
    logic                     regWrEn = 1'b0;
    logic                     regRdEn = 1'b0;
    logic [7:0]               regRdData, voice1Sample, voice3Sample, d, prev;
    logic [8:0]               dryMix, filterFeed;
    vsrmc_pkg::vsrmc_filter_t filterCtrl;
    int                       error_cnt = 0;
    int                       tests_run = 0;
    int                       nzV1, nzDry, nzFeed, steps;
    logic [4:0] ofs [13] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h0E, 5'h0F, 5'h12, 5'h15, 5'h16,
                             5'h17, 5'h18, 5'h1B, 5'h1F};
    logic [7:0] modes [6] = '{8'h4F, 8'h10, 8'h20, 8'h40, 8'h80, 8'h0F};
    logic [7:0] waves [4] = '{8'h11, 8'h09, 8'h19, 8'h1B};
    logic [7:0] mv [4] = '{8'h8F, 8'h8F, 8'h80, 8'h0F};
    logic       routes [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    // Short envelope step keeps attack within a few hundred cycles
    vsrmc_voice_ctrl #(.PHASE_W(24), .ENV_STEP_CYC(12'h001)) u_dut (
        .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .voice1Sample(voice1Sample), .voice3Sample(voice3Sample), .dryMix(dryMix),
        .filterFeed(filterFeed), .filterCtrl(filterCtrl));
    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    // Synchronous reset held for ten cycles, first request one edge after release
    task automatic do_reset;
        resetn = 1'b0;
        repeat (10) @(negedge core_clk);
        resetn = 1'b1;
        @(negedge core_clk);
    endtask : do_reset
    // One-cycle write strobe, driven from a falling edge
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        @(negedge core_clk);
        regWrEn = 1'b0;
        // Idle cycle so back-to-back writes never drive the strobe twice in one step
        @(negedge core_clk);
    endtask : wr
    // Read data is registered, so it is looked at one edge after the strobe
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge core_clk);
        regRdEn = 1'b0;
        chk("regRdData", {24'h0, regRdData}, {24'h0, e});
    endtask : rd
    // Counts cycles with nonzero audio on voice 1, the dry mix and the filter feed
    task automatic watch(input int n);
        nzV1 = 0;
        nzDry = 0;
        nzFeed = 0;
        repeat (n) begin
            @(negedge core_clk);
            nzV1 += (voice1Sample !== 8'h00);
            nzDry += (dryMix !== 9'h000);
            nzFeed += (filterFeed !== 9'h000);
        end
    endtask : watch
    // Watchdog well beyond the expected run of about 5000 cycles
    initial begin
        #100us;
        error_cnt++;
        final_report();
    end
    initial begin
        do_reset();
        // Reset values, write and readback; osc3 wave gets no waveform bits so its output stays 0
        for (int i = 0; i < 13; i++) begin
            d = (ofs[i] == 5'h12) ? 8'h0F : 8'hA5 ^ {3'h0, ofs[i]};
            rd(ofs[i], 8'h00);
            wr(ofs[i], d);
            rd(ofs[i],
               ofs[i] == 5'h15 ? d & 8'h07 : (ofs[i] >= 5'h1B ? 8'h00 : d));
        end
        // Second reset clears the phases that the table writes left running
        do_reset();
        for (int i = 0; i < 6; i++) begin
            wr(5'h18, modes[i]);
            @(negedge core_clk);
            chk("filterCtrl", {11'h0, filterCtrl},
                {24'h0, modes[i][6:4], modes[i][3:0], modes[i][7]});
        end
        wr(5'h16, 8'h68);
        wr(5'h15, 8'h05);
        wr(5'h17, 8'h01);
        @(negedge core_clk);
        chk("cutoffRoute", {20'h0, filterCtrl.cutoff, filterCtrl.routeV1},
            32'h0000068B);
        wr(5'h17, 8'h00);
        // Voice 3 rate follows its frequency high byte: stopped, then one step a cycle
        wr(5'h12, 8'h10);
        for (int k = 0; k < 2; k++) begin
            wr(5'h0F, k ? 8'h80 : 8'h00);
            repeat (4) @(negedge core_clk);
            steps = 0;
            repeat (8) begin
                prev = voice3Sample;
                @(negedge core_clk);
                steps += ((voice3Sample - prev) == 8'h01 || (voice3Sample - prev) == 8'hFF);
            end
            chk("voice3Steps", steps >= 7, k);
        end
        // Osc1 frozen at phase 0: only ring mixing with osc3 can make voice 1 sound
        wr(5'h05, 8'h0F);
        for (int i = 0; i < 4; i++) begin
            wr(5'h04, waves[i] & 8'hFE);
            wr(5'h04, waves[i]);
            watch(600);
            chk("voice1Active", nzV1 > 0, waves[i][3] & waves[i][4]);
        end
        // Routing, voice 3 mute and volume decide which mix carries sound
        for (int i = 0; i < 4; i++) begin
            wr(5'h17, {7'h0, routes[i]});
            wr(5'h18, mv[i]);
            watch(600);
            chk("dryMix", nzDry > 0,
                mv[i][3:0] != 0 && (!routes[i] || !mv[i][7]));
            chk("filterFeed", nzFeed > 0, mv[i][3:0] != 0 && routes[i]);
        end
        final_report();
    end
endmodule : vsrmc_voice_ctrl_tb
bind vsrmc_voice_ctrl vsrmc_voice_ctrl_assertions u_chk (
    .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .voice1Sample(voice1Sample), .voice3Sample(voice3Sample), .dryMix(dryMix),
    .filterFeed(filterFeed), .filterCtrl(filterCtrl));
